// ---- logic/isf_status_top.sv ----
// isf_status_top: status flags of a two-wire bus controller,
// with Avalon-MM registers, holding registers and interrupt.
// assumes the controller core drives the event inputs on clk_sys_in
// and the bus pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module isf_status_top #(
    parameter int DATA_W = 8
) (
    // clock, reset, enable
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    input  wire logic        ce_in,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // bus pins
    input  wire logic        scl_pin_in,
    input  wire logic        sda_pin_in,
    // controller core events
    input  wire logic        master_mode_in,
    input  wire logic        master_tx_start_in,
    input  wire logic        bus_collision_in,
    input  wire logic        gen_call_match_in,
    input  wire logic        addr10_match_in,
    input  wire logic        dev_addr_match_in,
    input  wire logic        addr_rw_bit_in,
    input  wire logic        module_busy_in,
    input  wire logic        tx_byte_taken_in,
    // to the core and system
    output logic [DATA_W-1:0] tx_data_out,
    output logic             irq_out
);
    generate
        if (DATA_W != isf_pkg::BYTE_BITS) begin : g_bad_width
            $error("DATA_W must equal the byte width");
        end
    endgenerate

    function automatic logic hit(input logic [4:0] a,
                                 input logic [4:0] o);
        hit = (a[4:2] == o[4:2]);
    endfunction

    // bus view
    logic [1:0] lvl, rise, fall;
    logic       start_p, stop_p, byte_done, ack_slot, ack_val;
    logic [7:0] rx_byte;

    isf_pin_sync #(
        .W (2)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .ce_in      (ce_in),
        .pin_in     ({sda_pin_in, scl_pin_in}),
        .lvl_out    (lvl),
        .rise_out   (rise),
        .fall_out   (fall)
    );

    isf_bit_track u_track (
        .clk_sys_in    (clk_sys_in),
        .reset_n_in    (reset_n_in),
        .ce_in         (ce_in),
        .scl_lvl_in    (lvl[0]),
        .scl_rise_in   (rise[0]),
        .sda_lvl_in    (lvl[1]),
        .sda_rise_in   (rise[1]),
        .sda_fall_in   (fall[1]),
        .start_out     (start_p),
        .stop_out      (stop_p),
        .byte_done_out (byte_done),
        .ack_slot_out  (ack_slot),
        .ack_val_out   (ack_val),
        .byte_out      (rx_byte)
    );

    // register bus: one wait state, action on the first edge
    logic        ack_r, ack_nxt;
    logic        acc, rd, wr;
    logic [31:0] rdata_r, rdata_nxt;

    assign acc = (avs_read_in | avs_write_in) & ~ack_r & ce_in;
    assign rd  = acc & avs_read_in;
    assign wr  = acc & avs_write_in;
    assign avs_waitrequest_out = (avs_read_in | avs_write_in)
                                 & ~(ack_r & ce_in);

    logic wr_stat, wr_tx, rd_rx, rd_irq, wr_mask;
    assign wr_stat = wr & hit(avs_address_in, isf_pkg::OFS_STATUS);
    assign wr_tx   = wr & hit(avs_address_in, isf_pkg::OFS_TX)
                     & avs_byteenable_in[0];
    assign rd_rx   = rd & hit(avs_address_in, isf_pkg::OFS_RX);
    assign rd_irq  = rd & hit(avs_address_in, isf_pkg::OFS_IRQ);
    assign wr_mask = wr & hit(avs_address_in, isf_pkg::OFS_MASK)
                     & avs_byteenable_in[0];

    // status flags and holding registers
    logic [15:0] stat_r, stat_nxt, sw_clr;
    logic [7:0]  tx_r, tx_nxt, rx_r, rx_nxt;
    logic        addressed_r, addressed_nxt;
    logic        tx_busy, tx_ok, rx_xfer;

    assign tx_busy = module_busy_in | stat_r[isf_pkg::TBF_BIT];
    assign tx_ok   = wr_tx & ~tx_busy;
    assign rx_xfer = byte_done & ~stat_r[isf_pkg::TRS_BIT];

    always_comb begin
        stat_nxt      = stat_r;
        tx_nxt        = tx_r;
        rx_nxt        = rx_r;
        addressed_nxt = addressed_r;
        // software clears a sticky flag by writing it as zero
        sw_clr = 16'h0000;
        if (wr_stat) begin
            sw_clr[isf_pkg::BCL_BIT] = avs_byteenable_in[1]
                & ~avs_writedata_in[isf_pkg::BCL_BIT];
            sw_clr[isf_pkg::WCOL_BIT] = avs_byteenable_in[0]
                & ~avs_writedata_in[isf_pkg::WCOL_BIT];
            sw_clr[isf_pkg::OVF_BIT] = avs_byteenable_in[0]
                & ~avs_writedata_in[isf_pkg::OVF_BIT];
        end
        stat_nxt = stat_nxt & ~sw_clr;
        if (ack_slot && stat_r[isf_pkg::TRS_BIT]) begin
            stat_nxt[isf_pkg::ACK_BIT] = ack_val;
            stat_nxt[isf_pkg::TRS_BIT] = 1'b0;
        end
        if (master_tx_start_in && master_mode_in) begin
            stat_nxt[isf_pkg::TRS_BIT] = 1'b1;
        end
        // set wins over a software clear in the same cycle
        if (bus_collision_in && master_mode_in) begin
            stat_nxt[isf_pkg::BCL_BIT] = 1'b1;
        end
        if (stop_p) begin
            stat_nxt[isf_pkg::GC_BIT]  = 1'b0;
            stat_nxt[isf_pkg::A10_BIT] = 1'b0;
            addressed_nxt = 1'b0;
        end
        if (gen_call_match_in) begin
            stat_nxt[isf_pkg::GC_BIT] = 1'b1;
        end
        if (addr10_match_in) begin
            stat_nxt[isf_pkg::A10_BIT] = 1'b1;
        end
        if (tx_byte_taken_in) begin
            stat_nxt[isf_pkg::TBF_BIT] = 1'b0;
        end
        if (wr_tx) begin
            if (tx_busy) begin
                stat_nxt[isf_pkg::WCOL_BIT] = 1'b1;
            end else begin
                tx_nxt = avs_writedata_in[7:0];
                stat_nxt[isf_pkg::TBF_BIT] = 1'b1;
            end
        end
        if (rd_rx) begin
            stat_nxt[isf_pkg::RBF_BIT] = 1'b0;
        end
        if (rx_xfer) begin
            if (stat_r[isf_pkg::RBF_BIT]) begin
                // old byte is kept, the new one is lost
                stat_nxt[isf_pkg::OVF_BIT] = 1'b1;
            end else begin
                rx_nxt = rx_byte;
                stat_nxt[isf_pkg::RBF_BIT] = 1'b1;
            end
        end
        if (dev_addr_match_in) begin
            stat_nxt[isf_pkg::DA_BIT] = 1'b0;
            stat_nxt[isf_pkg::RW_BIT] = addr_rw_bit_in;
            addressed_nxt = 1'b1;
        end else if (byte_done && !master_mode_in && addressed_r) begin
            stat_nxt[isf_pkg::DA_BIT] = 1'b1;
        end
        if (start_p) begin
            stat_nxt[isf_pkg::STOP_BIT] = 1'b0;
            stat_nxt[isf_pkg::STRT_BIT] = 1'b1;
        end else if (stop_p) begin
            stat_nxt[isf_pkg::STOP_BIT] = 1'b1;
            stat_nxt[isf_pkg::STRT_BIT] = 1'b0;
        end
        stat_nxt = stat_nxt & ~isf_pkg::STAT_RSVD;
        if (!ce_in) begin
            stat_nxt      = stat_r;
            tx_nxt        = tx_r;
            rx_nxt        = rx_r;
            addressed_nxt = addressed_r;
        end
    end

    // interrupt status, mask and output
    logic [5:0] ev, irqs_r, irqs_nxt, mask_r, mask_nxt;
    logic       irq_r, irq_nxt;

    always_comb begin
        ev = 6'h00;
        ev[isf_pkg::IRQ_RXB]  = rx_xfer;
        ev[isf_pkg::IRQ_STOP] = stop_p;
        ev[isf_pkg::IRQ_BCL]  = bus_collision_in & master_mode_in;
        ev[isf_pkg::IRQ_WCOL] = wr_tx & tx_busy;
        ev[isf_pkg::IRQ_OVF]  = rx_xfer & stat_r[isf_pkg::RBF_BIT];
        ev[isf_pkg::IRQ_ACKD] = ack_slot & stat_r[isf_pkg::TRS_BIT];
        // an event in the clearing read survives it
        irqs_nxt = (rd_irq ? 6'h00 : irqs_r) | ev;
        mask_nxt = wr_mask ? avs_writedata_in[5:0] : mask_r;
        if (!ce_in) begin
            irqs_nxt = irqs_r;
            mask_nxt = mask_r;
        end
        irq_nxt = |(irqs_nxt & mask_nxt);
    end

    // read data and handshake
    always_comb begin
        ack_nxt   = ce_in ? ((avs_read_in | avs_write_in) & ~ack_r)
                          : ack_r;
        rdata_nxt = rdata_r;
        if (rd) begin
            rdata_nxt = 32'h0000_0000;
            if (hit(avs_address_in, isf_pkg::OFS_STATUS)) begin
                rdata_nxt[15:0] = stat_r;
            end else if (hit(avs_address_in, isf_pkg::OFS_TX)) begin
                rdata_nxt[7:0] = tx_r;
            end else if (hit(avs_address_in, isf_pkg::OFS_RX)) begin
                rdata_nxt[7:0] = rx_r;
            end else if (hit(avs_address_in, isf_pkg::OFS_IRQ)) begin
                rdata_nxt[5:0] = irqs_r;
            end else if (hit(avs_address_in, isf_pkg::OFS_MASK)) begin
                rdata_nxt[5:0] = mask_r;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stat_r      <= isf_pkg::STAT_RST;
            tx_r        <= isf_pkg::DATA_RST;
            rx_r        <= isf_pkg::DATA_RST;
            addressed_r <= 1'b0;
            irqs_r      <= isf_pkg::IRQ_RST;
            mask_r      <= isf_pkg::IRQ_RST;
            irq_r       <= 1'b0;
            ack_r       <= 1'b0;
            rdata_r     <= 32'h0000_0000;
        end else begin
            stat_r      <= stat_nxt;
            tx_r        <= tx_nxt;
            rx_r        <= rx_nxt;
            addressed_r <= addressed_nxt;
            irqs_r      <= irqs_nxt;
            mask_r      <= mask_nxt;
            irq_r       <= irq_nxt;
            ack_r       <= ack_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign avs_readdata_out = rdata_r;
    assign tx_data_out      = tx_r;
    assign irq_out          = irq_r;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_ACK_RESULT: assert property (
        ce_in && ack_slot && stat_r[isf_pkg::TRS_BIT]
        |=> stat_r[isf_pkg::ACK_BIT] == $past(ack_val)
            && !stat_r[isf_pkg::TRS_BIT] || $past(master_tx_start_in))
        else $error("ack flag not taken from the ack slot");

    AST_TX_PROGRESS: assert property (
        ce_in && master_tx_start_in && master_mode_in
        |=> stat_r[isf_pkg::TRS_BIT])
        else $error("tx progress flag not set at transmit start");

    AST_COLLISION_STICKY: assert property (
        stat_r[isf_pkg::BCL_BIT] && !sw_clr[isf_pkg::BCL_BIT]
        |=> stat_r[isf_pkg::BCL_BIT])
        else $error("bus collision flag dropped without clear");

    AST_GCALL_STOP: assert property (
        ce_in && stop_p && !gen_call_match_in && !addr10_match_in
        |=> !stat_r[isf_pkg::GC_BIT] && !stat_r[isf_pkg::A10_BIT])
        else $error("address flags survive a stop");

    AST_TEN_BIT: assert property (
        ce_in && addr10_match_in |=> stat_r[isf_pkg::A10_BIT])
        else $error("ten-bit flag not set on match");

    AST_WRITE_COLLISION: assert property (
        wr_tx && tx_busy
        |=> stat_r[isf_pkg::WCOL_BIT] && $stable(tx_r))
        else $error("busy transmit write not rejected");

    AST_OVERFLOW: assert property (
        ce_in && rx_xfer && stat_r[isf_pkg::RBF_BIT]
        |=> stat_r[isf_pkg::OVF_BIT] && $stable(rx_r))
        else $error("overflow not flagged or byte overwritten");

    AST_DATA_ADDR: assert property (
        ce_in && dev_addr_match_in |=> !stat_r[isf_pkg::DA_BIT])
        else $error("data-or-address flag not cleared on match");

    AST_STOP_SEEN: assert property (
        ce_in && start_p
        |=> !stat_r[isf_pkg::STOP_BIT] && stat_r[isf_pkg::STRT_BIT])
        else $error("start did not clear stop-seen");

    AST_RESERVED_ZERO: assert property (
        (stat_r & isf_pkg::STAT_RSVD) == 16'h0000)
        else $error("unimplemented status bits set");
endmodule
`default_nettype wire

// ---- logic/isf_pkg.sv ----
// isf_pkg: constants shared by the two-wire status-flag block.
// assumes a 32-bit Avalon-MM register bus with byte addresses.
`default_nettype none
package isf_pkg;

    // register byte offsets
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_TX     = 5'h04;
    localparam logic [4:0] OFS_RX     = 5'h08;
    localparam logic [4:0] OFS_IRQ    = 5'h0c;
    localparam logic [4:0] OFS_MASK   = 5'h10;

    // serial_bus_status field positions
    localparam int STAT_W   = 16;
    localparam int ACK_BIT  = 15;
    localparam int TRS_BIT  = 14;
    localparam int BCL_BIT  = 10;
    localparam int GC_BIT   = 9;
    localparam int A10_BIT  = 8;
    localparam int WCOL_BIT = 7;
    localparam int OVF_BIT  = 6;
    localparam int DA_BIT   = 5;
    localparam int STOP_BIT = 4;
    localparam int STRT_BIT = 3;
    localparam int RW_BIT   = 2;
    localparam int RBF_BIT  = 1;
    localparam int TBF_BIT  = 0;

    // unimplemented bits 13..11
    localparam logic [15:0] STAT_RSVD = 16'h3800;
    localparam logic [15:0] STAT_RST  = 16'h0000;

    // interrupt status / mask layout
    localparam int IRQ_W     = 6;
    localparam int IRQ_RXB   = 0;
    localparam int IRQ_STOP  = 1;
    localparam int IRQ_BCL   = 2;
    localparam int IRQ_WCOL  = 3;
    localparam int IRQ_OVF   = 4;
    localparam int IRQ_ACKD  = 5;
    localparam logic [5:0] IRQ_RST = 6'h00;

    localparam logic [7:0] DATA_RST = 8'h00;
    localparam int BYTE_BITS = 8;

endpackage
`default_nettype wire

// ---- logic/isf_pin_sync.sv ----
// isf_pin_sync: two-flop synchroniser with edge detection.
// assumes inputs are asynchronous to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module isf_pin_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         reset_n_in,
    input  wire logic         ce_in,
    // pins
    input  wire logic [W-1:0] pin_in,
    // synchronised view
    output logic      [W-1:0] lvl_out,
    output logic      [W-1:0] rise_out,
    output logic      [W-1:0] fall_out
);
    generate
        if (W < 1) begin : g_bad_width
            $error("W must be at least one");
        end
    endgenerate

    // bus lines idle high, so reset to one
    logic [W-1:0] s1_r, s2_r, s3_r;
    logic [W-1:0] s1_nxt, s2_nxt, s3_nxt;

    always_comb begin
        s1_nxt = ce_in ? pin_in : s1_r;
        s2_nxt = ce_in ? s1_r : s2_r;
        s3_nxt = ce_in ? s2_r : s3_r;
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // first stage is read only by the second
    assign lvl_out  = s2_r;
    assign rise_out = s2_r & ~s3_r;
    assign fall_out = ~s2_r & s3_r;
endmodule
`default_nettype wire

// ---- logic/isf_bit_track.sv ----
// isf_bit_track: frames bus conditions, bytes and the acknowledge slot.
// assumes synchronised clock/data levels and edges on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module isf_bit_track (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic       ce_in,
    // synchronised bus view
    input  wire logic       scl_lvl_in,
    input  wire logic       scl_rise_in,
    input  wire logic       sda_lvl_in,
    input  wire logic       sda_rise_in,
    input  wire logic       sda_fall_in,
    // framing events as one-cycle pulses; ack level and received byte held
    output logic            start_out,
    output logic            stop_out,
    output logic            byte_done_out,
    output logic            ack_slot_out,
    output logic            ack_val_out,
    output logic [7:0]      byte_out
);
    logic       start_c, stop_c;
    logic       act_r, act_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic       st_r, st_nxt, sp_r, sp_nxt;
    logic       bd_r, bd_nxt, as_r, as_nxt, av_r, av_nxt;

    assign start_c = sda_fall_in & scl_lvl_in;
    assign stop_c  = sda_rise_in & scl_lvl_in;

    always_comb begin
        act_nxt = act_r;
        cnt_nxt = cnt_r;
        sh_nxt  = sh_r;
        av_nxt  = av_r;
        st_nxt  = 1'b0;
        sp_nxt  = 1'b0;
        bd_nxt  = 1'b0;
        as_nxt  = 1'b0;
        if (start_c) begin
            act_nxt = 1'b1;
            cnt_nxt = 4'h0;
            st_nxt  = 1'b1;
        end else if (stop_c) begin
            act_nxt = 1'b0;
            cnt_nxt = 4'h0;
            sp_nxt  = 1'b1;
        end else if (act_r && scl_rise_in) begin
            if (cnt_r == 4'(isf_pkg::BYTE_BITS)) begin
                // ninth clock: the acknowledge slot
                cnt_nxt = 4'h0;
                as_nxt  = 1'b1;
                av_nxt  = sda_lvl_in;
            end else begin
                sh_nxt  = {sh_r[6:0], sda_lvl_in};
                cnt_nxt = cnt_r + 4'h1;
                bd_nxt  = (cnt_r == 4'(isf_pkg::BYTE_BITS - 1));
            end
        end
        if (!ce_in) begin
            act_nxt = act_r;
            cnt_nxt = cnt_r;
            sh_nxt  = sh_r;
            av_nxt  = av_r;
            st_nxt  = st_r;
            sp_nxt  = sp_r;
            bd_nxt  = bd_r;
            as_nxt  = as_r;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            act_r <= 1'b0;
            cnt_r <= 4'h0;
            sh_r  <= isf_pkg::DATA_RST;
            av_r  <= 1'b0;
            st_r  <= 1'b0;
            sp_r  <= 1'b0;
            bd_r  <= 1'b0;
            as_r  <= 1'b0;
        end else begin
            act_r <= act_nxt;
            cnt_r <= cnt_nxt;
            sh_r  <= sh_nxt;
            av_r  <= av_nxt;
            st_r  <= st_nxt;
            sp_r  <= sp_nxt;
            bd_r  <= bd_nxt;
            as_r  <= as_nxt;
        end
    end

    assign start_out     = st_r;
    assign stop_out      = sp_r;
    assign byte_done_out = bd_r;
    assign ack_slot_out  = as_r;
    assign ack_val_out   = av_r;
    assign byte_out      = sh_r;
endmodule
`default_nettype wire

// ---- dv/isf_bus_model.sv ----
// isf_bus_model: far-side device of the two-wire bus.
// assumes pull-ups, so a released line reads high; clock idles high.
`timescale 1ns/1ps
`default_nettype none
module isf_bus_model (
    // bus lines
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // one 400 ns slot; data moves only while the clock is low
    task automatic put(input logic b);
        sda_out = b;
        #100 scl_out = 1'b1;
        #200 scl_out = 1'b0;
        #100;
    endtask
    task automatic start_cond();
        sda_out = 1'b1;
        #100 scl_out = 1'b1;
        #100 sda_out = 1'b0;
        #200 scl_out = 1'b0;
        #100;
    endtask
    task automatic stop_cond();
        sda_out = 1'b0;
        #100 scl_out = 1'b1;
        #200 sda_out = 1'b1;
        #200;
    endtask
    // msb first, then the ack slot; data line released afterwards
    task automatic send(input logic [7:0] b, input logic nack);
        for (int i = 7; i >= 0; i--) begin
            put(b[i]);
        end
        put(nack);
        sda_out = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_i2c_status_flag_logic.sv ----
// tb_i2c_status_flag_logic: self-checking bench of the status flags.
// assumes isf_bus_model on the pins; core events driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_status_flag_logic;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic [4:0]  addr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wait_req;
    logic        scl;
    logic        sda;
    logic        master;
    logic        rw_bit;
    logic        busy;
    logic [5:0]  ev;
    logic [7:0]  tx_data;
    logic        irq;
    int          failures;
    int          checks_done;

    isf_bus_model bus (.scl_out(scl), .sda_out(sda));

    isf_status_top #(.DATA_W(8)) dut (
        .clk_sys_in(clk), .reset_n_in(rst_n), .ce_in(ce),
        .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
        .scl_pin_in(scl), .sda_pin_in(sda), .master_mode_in(master),
        .master_tx_start_in(ev[0]), .bus_collision_in(ev[1]),
        .gen_call_match_in(ev[2]), .addr10_match_in(ev[3]),
        .dev_addr_match_in(ev[4]), .addr_rw_bit_in(rw_bit),
        .module_busy_in(busy), .tx_byte_taken_in(ev[5]),
        .tx_data_out(tx_data), .irq_out(irq)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus_op(input logic wr, input logic [4:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        rd_en <= !wr;
        wr_en <= wr;
        wdata <= d;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        q = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_op(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] m,
                          input logic [15:0] e);
        logic [31:0] q;
        bus_op(1'b0, a, 32'h0000_0000, q);
        chk({16'h0000, q[15:0] & m}, {16'h0000, e});
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask

    // covers the pin synchroniser plus the one-cycle flag update
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        bus_op(1'b0, isf_pkg::OFS_STATUS, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd_chk(5'h14, 16'hffff, 16'h0000);
    endtask

    task automatic t_master_tx();
        logic [31:0] q;
        pulse(0);
        settle();
        rd_chk(isf_pkg::OFS_STATUS, 16'h4000, 16'h4000);
        bus.start_cond();
        bus.send(8'ha6, 1'b1);
        settle();
        rd_chk(isf_pkg::OFS_STATUS, 16'hc018, 16'h8008);
        pulse(0);
        bus.send(8'h59, 1'b0);
        settle();
        rd_chk(isf_pkg::OFS_STATUS, 16'hc000, 16'h0000);
        pulse(1);
        settle();
        bus_op(1'b0, isf_pkg::OFS_STATUS, 32'h0000_0000, q);
        chk(q & 32'hffff_3c00, 32'h0000_0400);
        wr(isf_pkg::OFS_STATUS, 32'h0000_0000);
        rd_chk(isf_pkg::OFS_STATUS, 16'h0400, 16'h0000);
    endtask

    task automatic t_stop_flags();
        pulse(2);
        pulse(3);
        settle();
        rd_chk(isf_pkg::OFS_STATUS, 16'h0300, 16'h0300);
        bus.stop_cond();
        settle();
        rd_chk(isf_pkg::OFS_STATUS, 16'h0318, 16'h0010);
    endtask

    task automatic t_tx_wcol();
        wr(isf_pkg::OFS_TX, 32'h0000_00a5);
        chk({24'h00_0000, tx_data}, 32'h0000_00a5);
        rd_chk(isf_pkg::OFS_STATUS, 16'h0081, 16'h0001);
        busy <= 1'b1;
        wr(isf_pkg::OFS_TX, 32'h0000_005a);
        chk({24'h00_0000, tx_data}, 32'h0000_00a5);
        rd_chk(isf_pkg::OFS_STATUS, 16'h0080, 16'h0080);
        busy <= 1'b0;
        pulse(5);
        wr(isf_pkg::OFS_STATUS, 32'h0000_0000);
        rd_chk(isf_pkg::OFS_STATUS, 16'h0081, 16'h0000);
    endtask

    task automatic t_slave_rx();
        master <= 1'b0;
        wr(isf_pkg::OFS_MASK, 32'h0000_0010);
        bus.start_cond();
        @(posedge clk);
        rw_bit <= 1'b1;
        pulse(4);
        settle();
        rd_chk(isf_pkg::OFS_STATUS, 16'h0024, 16'h0004);
        bus.send(8'h3c, 1'b0);
        settle();
        rd_chk(isf_pkg::OFS_STATUS, 16'h0022, 16'h0022);
        rd_chk(isf_pkg::OFS_RX, 16'h00ff, 16'h003c);
        rd_chk(isf_pkg::OFS_STATUS, 16'h0002, 16'h0000);
        bus.send(8'hc3, 1'b0);
        bus.send(8'h96, 1'b0);
        settle();
        rd_chk(isf_pkg::OFS_STATUS, 16'h0040, 16'h0040);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rd_chk(isf_pkg::OFS_IRQ, 16'h0010, 16'h0010);
        repeat (2) @(posedge clk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd_chk(isf_pkg::OFS_RX, 16'h00ff, 16'h00c3);
        wr(isf_pkg::OFS_STATUS, 32'h0000_0000);
        rd_chk(isf_pkg::OFS_STATUS, 16'h0040, 16'h0000);
        bus.stop_cond();
    endtask

    // events offered while the enable is low must leave no trace
    task automatic t_clk_enable();
        @(posedge clk);
        ce <= 1'b0;
        pulse(2);
        pulse(3);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(isf_pkg::OFS_STATUS, 16'h0300, 16'h0000);
    endtask

    // second reset with flags, holding data and mask all non-zero
    task automatic t_mid_reset();
        logic [31:0] q;
        bus_op(1'b0, isf_pkg::OFS_STATUS, 32'h0000_0000, q);
        chk(q & 32'h0000_0034, 32'h0000_0034);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus_op(1'b0, isf_pkg::OFS_STATUS, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        chk({24'h00_0000, tx_data}, 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd_chk(isf_pkg::OFS_MASK, 16'hffff, 16'h0000);
    endtask

    initial begin
        #200000;
        failures++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        addr = 5'h00;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdata = 32'h0000_0000;
        master = 1'b1;
        rw_bit = 1'b0;
        busy = 1'b0;
        ce = 1'b1;
        ev = 6'h00;
        failures = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_master_tx();
        t_stop_flags();
        t_tx_wcol();
        t_clk_enable();
        t_slave_rx();
        t_mid_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
